// ==== inc/fpes_pkg.sv ====
package fpes_pkg;
  // register byte offsets
  localparam logic [7:0] BUSY_STATUS_OFS = 8'h00;
  localparam logic [7:0] CE_STATUS_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] CE_STATUS_RMW_OFS = 8'h0c;
  localparam logic [7:0] SECTOR_WE_OFS = 8'h10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // flash_busy_status fields
  localparam int BS_CE_BUSY = 4;
  localparam int BS_SUSP_BUSY = 3;
  localparam int BS_SE_BUSY = 2;
  localparam int BS_PGM_BUSY = 1;
  localparam int BS_HANG = 0;
  // chip_erase_status fields
  localparam int CS_DONE = 6;
  localparam int CS_IRQ_EN = 5;
  localparam int CS_FAIL = 4;
  // control fields
  localparam int CT_SWAP = 0;
  localparam int CT_GPE = 1;
  localparam int SECTORS = 4;
  // synchronised flash-side input vector
  localparam int FI_CE_BUSY = 0;
  localparam int FI_SUSP_BUSY = 1;
  localparam int FI_SE_BUSY = 2;
  localparam int FI_PGM_BUSY = 3;
  localparam int FI_HANG = 4;
  localparam int FI_CE_FAIL = 5;
  localparam int FI_RST_CMD = 6;
  localparam int FI_W = 7;
  // reset values
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_NIB = 4'h0;
  localparam logic [3:0] ONES_NIB = 4'hf;
  // timing
  localparam int MCLK_PERIOD_NS = 20;
  localparam int PGM_STATUS_MAX_PERIOD_NS = 1000;
  localparam bit PGM_STATUS_OK = (MCLK_PERIOD_NS <= PGM_STATUS_MAX_PERIOD_NS);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } fpes_bus_state_t;
endpackage : fpes_pkg

// ==== inc/fpes_reg_if.sv ====
`timescale 1ns/1ps
interface fpes_reg_if;
  import fpes_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, output wr_addr, output wr_data, input wr_ok,
               output rd_addr, input rd_data, input rd_ok);
  modport regs (input wr_en, input wr_addr, input wr_data, output wr_ok,
                input rd_addr, output rd_data, output rd_ok);
endinterface : fpes_reg_if

// ==== rtl/fpes_axil_slave.sv ====
`timescale 1ns/1ps
module fpes_axil_slave
  import fpes_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronised reset
  fpes_reg_if.bus rif, // register access
  input wire logic [31:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [31:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);
  fpes_bus_state_t wst_reg, wst_next, rst_reg, rst_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] awa_reg, awa_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic wlane_reg, wlane_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  assign awready = (wst_reg == ST_IDLE) && !aw_have_reg;
  assign wready = (wst_reg == ST_IDLE) && !w_have_reg;
  assign bvalid = (wst_reg == ST_RESP);
  assign bresp = bresp_reg;
  assign arready = (rst_reg == ST_IDLE);
  assign rvalid = (rst_reg == ST_RESP);
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign rif.rd_addr = araddr[ADDR_W-1:0];
  assign rif.wr_addr = awa_reg;
  assign rif.wr_data = wd_reg;
  // a write without lane 0 has nothing to store but still gets its answer
  assign rif.wr_en = (wst_reg == ST_IDLE) && aw_have_reg && w_have_reg && wlane_reg;

  always_comb
  begin
    wst_next = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    wlane_next = wlane_reg;
    bresp_next = bresp_reg;
    unique case (wst_reg)
      ST_IDLE:
      begin
        if (awvalid && !aw_have_reg)
        begin
          aw_have_next = 1'b1;
          awa_next = awaddr[ADDR_W-1:0];
        end
        if (wvalid && !w_have_reg)
        begin
          w_have_next = 1'b1;
          wd_next = wdata[DATA_W-1:0];
          wlane_next = wstrb[0];
        end
        if (aw_have_reg && w_have_reg)
        begin
          bresp_next = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wst_next = ST_RESP;
        end
      end
      ST_RESP:
      begin
        if (bready)
        begin
          wst_next = ST_IDLE;
        end
      end
    endcase
  end

  always_comb
  begin
    rst_next = rst_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    unique case (rst_reg)
      ST_IDLE:
      begin
        if (arvalid)
        begin
          rdata_next = {24'h000000, rif.rd_data};
          rresp_next = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
          rst_next = ST_RESP;
        end
      end
      ST_RESP:
      begin
        if (rready)
        begin
          rst_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wst_reg <= ST_IDLE;
      rst_reg <= ST_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awa_reg <= ZERO_BYTE;
      wd_reg <= ZERO_BYTE;
      wlane_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wst_reg <= wst_next;
      rst_reg <= rst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      wlane_reg <= wlane_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : fpes_axil_slave

// ==== rtl/fpes_top.sv ====
// Contract
// [R1] swap off: enable sectors 0 and 1 together; code enables each sector from its own bit, swap ignored
// [R2] swap on: enable all four sectors first; code sets swap whatever the sector enables hold
// [R3] unused status bits read zero, ignore writes
// [R4] chip erase busy flag in bit 4
// [R5] erase suspend busy flag in bit 3
// [R6] sector erase busy flag in bit 2
// [R7] program busy flag, never with slow clock
// [R8] hang flag sticks once malfunction seen
// [R9] chip erase success sets done flag
// [R10] failed erase with hang clears done
// [R11] failed chip erase sets failure flag
// [R12] refuse program/erase after chip erase end
// [R13] interrupt when failure flag and enable
// [R14] write zero clears flag, one keeps
// [R15] rmw read returns both flags as one
// [R16] global enable off blocks all sector writes
// [R17] software order: global, sectors, sequence, off
// [R18] program sequence AA, 55, A0, data
// [R19] poll data bit, check timeout bit
// [R20] dual operation: poll, never toggle bit
// [R21] interrupt level until flag or enable cleared
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module fpes_top
  import fpes_pkg::*;
(
  input wire logic CORE_CLK, // machine clock
  input wire logic ARST_N, // async reset, active low
  input wire logic [31:0] AWADDR, // axi write address
  input wire logic AWVALID, // axi write address valid
  output logic AWREADY, // axi write address ready
  input wire logic [31:0] WDATA, // axi write data
  input wire logic [3:0] WSTRB, // axi byte strobes
  input wire logic WVALID, // axi write data valid
  output logic WREADY, // axi write data ready
  output logic [1:0] BRESP, // axi write response
  output logic BVALID, // axi write response valid
  input wire logic BREADY, // axi write response ready
  input wire logic [31:0] ARADDR, // axi read address
  input wire logic ARVALID, // axi read address valid
  output logic ARREADY, // axi read address ready
  output logic [31:0] RDATA, // axi read data
  output logic [1:0] RRESP, // axi read response
  output logic RVALID, // axi read valid
  input wire logic RREADY, // axi read ready
  input wire logic FLASH_CE_BUSY, // array: chip erase running
  input wire logic FLASH_SUSP_BUSY, // array: erase suspend taking effect
  input wire logic FLASH_SE_BUSY, // array: sector erase running
  input wire logic FLASH_PGM_BUSY, // array: program running
  input wire logic FLASH_HANG, // array: command input malfunction
  input wire logic FLASH_CE_FAIL, // array: chip erase failed, valid at end
  input wire logic FLASH_RESET_CMD, // reset command written
  output logic [3:0] SECTOR_WRITE_ALLOW, // per sector program/erase allowed
  output logic PROG_ERASE_ALLOW, // program/erase allowed globally (enable set, no chip erase lock), whatever the sector enables
  output logic SECTOR_SWAP_EN, // sector swap setting
  output logic IRQ // chip erase failure interrupt
);
  fpes_reg_if rif ();
  logic rst_s1_reg, rst_n;
  logic [FI_W-1:0] fin_s1_reg, fin_s2_reg;
  logic ce_busy_prev_reg, rcmd_prev_reg;
  logic hang_reg, hang_next;
  logic ce_done_reg, ce_done_next;
  logic ce_fail_reg, ce_fail_next;
  logic irq_en_reg, irq_en_next;
  logic ce_lock_reg, ce_lock_next;
  logic swap_reg, swap_next;
  logic gpe_reg, gpe_next;
  logic [3:0] sect_en_reg, sect_en_next;
  logic [3:0] sect_lock_reg, sect_lock_next;
  logic [3:0] allow_reg, allow_next;
  logic any_allow_reg, any_allow_next;
  logic irq_reg, irq_next;
  logic ce_end, ce_failed, rst_cmd, wr_ce, wr_ctrl, wr_sect;
  logic [7:0] busy_view, ce_view;

  // write-zero-to-clear flag; a hardware set in the same cycle wins
  function automatic logic wzc(input logic cur, input logic set, input logic wr,
                               input logic wbit);
    wzc = set ? 1'b1 : ((wr && !wbit) ? 1'b0 : cur);
  endfunction : wzc

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  fpes_axil_slave u_bus (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .rif(rif.bus),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY)
  );

  // array status comes from another timing domain, so sync before use
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fin_s1_reg <= '0;
      fin_s2_reg <= '0;
      ce_busy_prev_reg <= 1'b0;
      rcmd_prev_reg <= 1'b0;
    end
    else
    begin
      fin_s1_reg <= {FLASH_RESET_CMD, FLASH_CE_FAIL, FLASH_HANG, FLASH_PGM_BUSY,
                     FLASH_SE_BUSY, FLASH_SUSP_BUSY, FLASH_CE_BUSY};
      fin_s2_reg <= fin_s1_reg;
      ce_busy_prev_reg <= fin_s2_reg[FI_CE_BUSY];
      rcmd_prev_reg <= fin_s2_reg[FI_RST_CMD];
    end
  end

  // end of the automatic algorithm is the fall of chip erase busy
  assign ce_end = ce_busy_prev_reg && !fin_s2_reg[FI_CE_BUSY];
  assign ce_failed = fin_s2_reg[FI_CE_FAIL];
  assign rst_cmd = fin_s2_reg[FI_RST_CMD] && !rcmd_prev_reg;
  assign wr_ce = rif.wr_en && addr_is(rif.wr_addr, CE_STATUS_OFS);
  assign wr_ctrl = rif.wr_en && addr_is(rif.wr_addr, CTRL_OFS);
  assign wr_sect = rif.wr_en && addr_is(rif.wr_addr, SECTOR_WE_OFS);

  always_comb
  begin
    busy_view = ZERO_BYTE;
    // [R4] chip erase busy
    busy_view[BS_CE_BUSY] = fin_s2_reg[FI_CE_BUSY];
    // [R5] suspend busy
    busy_view[BS_SUSP_BUSY] = fin_s2_reg[FI_SUSP_BUSY];
    // [R6] sector erase busy
    busy_view[BS_SE_BUSY] = fin_s2_reg[FI_SE_BUSY];
    // [R7] program busy, clock-gated
    busy_view[BS_PGM_BUSY] = fin_s2_reg[FI_PGM_BUSY] && PGM_STATUS_OK;
    busy_view[BS_HANG] = hang_reg;
    // [R3] unused bits stay zero
    ce_view = ZERO_BYTE;
    ce_view[CS_DONE] = ce_done_reg;
    ce_view[CS_IRQ_EN] = irq_en_reg;
    ce_view[CS_FAIL] = ce_fail_reg;
  end

  always_comb
  begin
    rif.rd_ok = 1'b1;
    rif.rd_data = ZERO_BYTE;
    rif.wr_ok = addr_is(rif.wr_addr, CE_STATUS_OFS) || addr_is(rif.wr_addr, CTRL_OFS)
                || addr_is(rif.wr_addr, SECTOR_WE_OFS);
    if (addr_is(rif.rd_addr, BUSY_STATUS_OFS))
      rif.rd_data = busy_view;
    else if (addr_is(rif.rd_addr, CE_STATUS_OFS))
      rif.rd_data = ce_view;
    else if (addr_is(rif.rd_addr, CE_STATUS_RMW_OFS))
    begin
      rif.rd_data = ce_view;
      // [R15] rmw view reads done and fail as ones
      rif.rd_data[CS_DONE] = 1'b1;
      rif.rd_data[CS_FAIL] = 1'b1;
    end
    else if (addr_is(rif.rd_addr, CTRL_OFS))
      rif.rd_data = {6'h00, gpe_reg, swap_reg};
    else if (addr_is(rif.rd_addr, SECTOR_WE_OFS))
      rif.rd_data = {ZERO_NIB, sect_en_reg};
    else
      rif.rd_ok = 1'b0;
  end

  always_comb
  begin
    // [R8] hang is sticky
    hang_next = hang_reg || fin_s2_reg[FI_HANG];
    // [R9] [R10] [R14] done set, hang-fail clear, write-zero clear
    ce_done_next = wzc(ce_done_reg, ce_end && !ce_failed, wr_ce, rif.wr_data[CS_DONE]);
    if (ce_end && ce_failed && fin_s2_reg[FI_HANG])
      ce_done_next = 1'b0;
    // [R11] [R14] failure flag
    ce_fail_next = wzc(ce_fail_reg, ce_end && ce_failed, wr_ce, rif.wr_data[CS_FAIL]);
    irq_en_next = wr_ce ? rif.wr_data[CS_IRQ_EN] : irq_en_reg;
    // [R12] lock after chip erase end until reset command
    ce_lock_next = ce_end ? 1'b1 : (rst_cmd ? 1'b0 : ce_lock_reg);
    swap_next = wr_ctrl ? rif.wr_data[CT_SWAP] : swap_reg;
    gpe_next = wr_ctrl ? rif.wr_data[CT_GPE] : gpe_reg;
    // a sector written to zero stays off until reset
    sect_lock_next = wr_sect ? (sect_lock_reg | ~rif.wr_data[SECTORS-1:0]) : sect_lock_reg;
    sect_en_next = wr_sect ? (rif.wr_data[SECTORS-1:0] & ~sect_lock_next) : sect_en_reg;
    // [R16] [R12] global gate and chip erase lock; swap plays no part
    allow_next = (gpe_reg && !ce_lock_reg) ? sect_en_reg : ZERO_NIB;
    any_allow_next = gpe_reg && !ce_lock_reg;
    // [R13] [R21] level interrupt
    irq_next = ce_fail_reg && irq_en_reg;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hang_reg <= 1'b0;
      ce_done_reg <= 1'b0;
      ce_fail_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      ce_lock_reg <= 1'b0;
      swap_reg <= 1'b0;
      gpe_reg <= 1'b0;
      sect_en_reg <= ZERO_NIB;
      sect_lock_reg <= ZERO_NIB;
      allow_reg <= ZERO_NIB;
      any_allow_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      hang_reg <= hang_next;
      ce_done_reg <= ce_done_next;
      ce_fail_reg <= ce_fail_next;
      irq_en_reg <= irq_en_next;
      ce_lock_reg <= ce_lock_next;
      swap_reg <= swap_next;
      gpe_reg <= gpe_next;
      sect_en_reg <= sect_en_next;
      sect_lock_reg <= sect_lock_next;
      allow_reg <= allow_next;
      any_allow_reg <= any_allow_next;
      irq_reg <= irq_next;
    end
  end

  assign SECTOR_WRITE_ALLOW = allow_reg;
  assign PROG_ERASE_ALLOW = any_allow_reg;
  assign SECTOR_SWAP_EN = swap_reg;
  assign IRQ = irq_reg;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  a_status_pad: assert property ( // [R3]
    rif.rd_ok && !addr_is(rif.rd_addr, CE_STATUS_RMW_OFS) |->
      rif.rd_data[7:5] == 3'h0 || addr_is(rif.rd_addr, CE_STATUS_OFS))
    else $error("unused busy status bits not zero");
  a_ce_pad: assert property ( // [R3]
    addr_is(rif.rd_addr, CE_STATUS_OFS) |-> rif.rd_data[7] == 1'b0 && rif.rd_data[3:0] == ZERO_NIB)
    else $error("unused chip erase status bits not zero");
  a_ce_busy_view: assert property ( // [R4]
    addr_is(rif.rd_addr, BUSY_STATUS_OFS) |-> rif.rd_data[BS_CE_BUSY] == fin_s2_reg[FI_CE_BUSY])
    else $error("chip erase busy view wrong");
  a_susp_view: assert property ( // [R5]
    addr_is(rif.rd_addr, BUSY_STATUS_OFS) |-> rif.rd_data[BS_SUSP_BUSY] == fin_s2_reg[FI_SUSP_BUSY])
    else $error("suspend busy view wrong");
  a_se_view: assert property ( // [R6]
    addr_is(rif.rd_addr, BUSY_STATUS_OFS) |-> rif.rd_data[BS_SE_BUSY] == fin_s2_reg[FI_SE_BUSY])
    else $error("sector erase busy view wrong");
  a_pgm_view: assert property ( // [R7]
    addr_is(rif.rd_addr, BUSY_STATUS_OFS) |-> rif.rd_data[BS_PGM_BUSY] == fin_s2_reg[FI_PGM_BUSY])
    else $error("program busy view wrong");
  a_hang_sticky: assert property ( // [R8]
    hang_reg |=> hang_reg[*8])
    else $error("hang flag dropped");
  a_done_set: assert property ( // [R9]
    ce_end && !ce_failed |=> ce_done_reg)
    else $error("done not set on successful erase");
  a_done_fail_clr: assert property ( // [R10]
    ce_end && ce_failed && fin_s2_reg[FI_HANG] |=> !ce_done_reg)
    else $error("done not cleared on hung failure");
  a_fail_set: assert property ( // [R11]
    ce_end && ce_failed |=> ce_fail_reg)
    else $error("failure flag not set");
  a_lock_refuse: assert property ( // [R12]
    ce_end |-> ##2 (!PROG_ERASE_ALLOW && SECTOR_WRITE_ALLOW == ZERO_NIB) [*2])
    else $error("program allowed after chip erase end");
  a_irq_level: assert property ( // [R13]
    ce_fail_reg && irq_en_reg |=> IRQ)
    else $error("interrupt missing");
  a_irq_drop: assert property ( // [R21]
    IRQ && $fell(ce_fail_reg) |=> !IRQ)
    else $error("interrupt stayed after flag clear");
  a_write_one_keeps: assert property ( // [R14]
    wr_ce && rif.wr_data[CS_DONE] && ce_done_reg && !ce_end |=> ce_done_reg)
    else $error("writing one changed done flag");
  a_rmw_ones: assert property ( // [R15]
    addr_is(rif.rd_addr, CE_STATUS_RMW_OFS) |-> rif.rd_data[CS_DONE] && rif.rd_data[CS_FAIL])
    else $error("rmw view not ones");
  a_gpe_gate: assert property ( // [R16]
    !gpe_reg |=> SECTOR_WRITE_ALLOW == ZERO_NIB && !PROG_ERASE_ALLOW)
    else $error("sector write allowed without global enable");

  c_ce_ok: cover property (ce_end && !ce_failed ##1 ce_done_reg);
  c_ce_fail_irq: cover property (ce_end && ce_failed ##[1:4] IRQ);
  c_unlock: cover property (ce_lock_reg ##1 !ce_lock_reg);
  c_allow: cover property (SECTOR_WRITE_ALLOW == ONES_NIB);
endmodule : fpes_top

// ==== tb/fpes_flash_model.sv ====
`timescale 1ns/1ps
module fpes_flash_model (
  input wire logic clk, // core clock
  output logic [2:0] op_busy = 3'h0, // program, sector erase, suspend
  output logic ce_busy = 1'b0, // chip erase running
  output logic hang = 1'b0, // command malfunction seen
  output logic ce_fail = 1'b0, // chip erase result line
  output logic rst_cmd = 1'b0 // reset command level
);
  // one busy pulse stands for a whole command sequence
  task automatic op(input int i, input int n);
    @(posedge clk);
    op_busy[i] <= 1'b1;
    repeat (n) @(posedge clk);
    op_busy[i] <= 1'b0;
  endtask : op

  task automatic chip_erase(input logic f, input logic h, input int n);
    @(posedge clk);
    ce_busy <= 1'b1;
    // result line holds the wrong value until 2 cycles before busy falls, so a latch taken early shows up
    ce_fail <= ~f;
    repeat (n) @(posedge clk);
    ce_fail <= f;
    hang <= h;
    repeat (2) @(posedge clk);
    ce_busy <= 1'b0;
    repeat (6) @(posedge clk);
    ce_fail <= ~f;
  endtask : chip_erase

  task automatic reset_cmd();
    @(posedge clk);
    rst_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    rst_cmd <= 1'b0;
    hang <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : reset_cmd
endmodule : fpes_flash_model

// ==== tb/flash_prog_erase_status_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module flash_prog_erase_status_tb_top;
  import fpes_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [1:0] rs;
    logic [3:0] al;} fpes_row_t;
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [31:0] AWADDR = 32'h0;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] ARADDR = 32'h0;
  logic [3:0] WSTRB = 4'h1;
  logic AWVALID = 1'b0;
  logic WVALID = 1'b0;
  logic BREADY = 1'b0;
  logic ARVALID = 1'b0;
  logic RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PROG_ERASE_ALLOW, SECTOR_SWAP_EN, IRQ;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [3:0] SECTOR_WRITE_ALLOW;
  logic [2:0] op_busy;
  logic ce_busy, hang, ce_fail, rst_cmd;
  int mismatches = 0;
  int cmp_count = 0;
  int bpos [3] = '{BS_PGM_BUSY, BS_SE_BUSY, BS_SUSP_BUSY};
  // global enable first, then all sectors
  fpes_row_t rows [17] = '{
    '{1'b0, 8'h00, 8'h00, 2'h0, 4'h0}, '{1'b0, 8'h04, 8'h00, 2'h0, 4'h0},
    '{1'b0, 8'h08, 8'h00, 2'h0, 4'h0}, '{1'b0, 8'h10, 8'h00, 2'h0, 4'h0},
    '{1'b1, 8'h04, 8'hff, 2'h0, 4'h0}, '{1'b0, 8'h04, 8'h20, 2'h0, 4'h0},
    '{1'b0, 8'h0c, 8'h70, 2'h0, 4'h0}, '{1'b1, 8'h00, 8'hff, 2'h2, 4'h0},
    '{1'b0, 8'h00, 8'h00, 2'h0, 4'h0}, '{1'b0, 8'h14, 8'h00, 2'h2, 4'h0},
    '{1'b1, 8'h14, 8'hff, 2'h2, 4'h0}, '{1'b1, 8'h08, 8'h02, 2'h0, 4'h0},
    '{1'b1, 8'h10, 8'h0f, 2'h0, 4'hf}, '{1'b0, 8'h10, 8'h0f, 2'h0, 4'hf},
    '{1'b1, 8'h08, 8'h00, 2'h0, 4'h0}, '{1'b1, 8'h08, 8'h03, 2'h0, 4'hf},
    '{1'b0, 8'h08, 8'h03, 2'h0, 4'hf}};

  always #10 CORE_CLK = ~CORE_CLK;

  fpes_flash_model model (.clk(CORE_CLK), .op_busy(op_busy), .ce_busy(ce_busy), .hang(hang),
    .ce_fail(ce_fail), .rst_cmd(rst_cmd));

  fpes_top dut (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .FLASH_CE_BUSY(ce_busy), .FLASH_SUSP_BUSY(op_busy[2]), .FLASH_SE_BUSY(op_busy[1]),
    .FLASH_PGM_BUSY(op_busy[0]), .FLASH_HANG(hang), .FLASH_CE_FAIL(ce_fail),
    .FLASH_RESET_CMD(rst_cmd), .SECTOR_WRITE_ALLOW(SECTOR_WRITE_ALLOW),
    .PROG_ERASE_ALLOW(PROG_ERASE_ALLOW), .SECTOR_SWAP_EN(SECTOR_SWAP_EN), .IRQ(IRQ));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : tick

  // a stuck handshake ends the run through the one closing report
  task automatic wait_edge(inout int n);
    @(posedge CORE_CLK);
    n++;
    if (n > 60)
    begin
      mismatches++;
      $display("CHECK FAILED bus handshake exp %h got %h", 1'b1, 1'b0);
      results();
    end
  endtask : wait_edge

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    AWADDR <= {24'h0, a};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(ad && wd))
    begin
      wait_edge(n);
      if (AWREADY === 1'b1)
        ad = 1'b1;
      if (WREADY === 1'b1)
        wd = 1'b1;
      if (ad)
        AWVALID <= 1'b0;
      if (wd)
        WVALID <= 1'b0;
    end
    do
      wait_edge(n);
    while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    ARADDR <= {24'h0, a};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
      wait_edge(n);
    while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do
      wait_edge(n);
    while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK("rdata", {24'h0, e}, d)
    `CHK("rresp", RESP_OKAY, r)
  endtask : rc

  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wc

  // poll the busy view, never a toggling bit, with a bound
  task automatic poll_idle(input logic [7:0] m);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    k = 0;
    d = 32'hffffffff;
    while ((d[7:0] & m) != 8'h00 && k < 20)
    begin
      rd(BUSY_STATUS_OFS, d, r);
      k++;
    end
    `CHK("poll idle", 8'h00, d[7:0] & m)
  endtask : poll_idle

  initial
  begin
    logic [31:0] dd;
    logic [1:0] r;
    tick(16);
    ARST_N <= 1'b1;
    tick(4);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d, r);
      else
        rd(rows[i].a, dd, r);
      if (!rows[i].wr)
        `CHK("rdata", {24'h0, rows[i].d}, dd)
      `CHK("resp", rows[i].rs, r)
      tick(2);
      `CHK("sector allow", rows[i].al, SECTOR_WRITE_ALLOW)
    end
    // a write without lane 0 is answered but stores nothing
    WSTRB <= 4'h0;
    wc(CTRL_OFS, 8'h00);
    WSTRB <= 4'h1;
    rc(CTRL_OFS, 8'h03);
    `CHK("swap", 1'b1, SECTOR_SWAP_EN)
    `CHK("prog allow", 1'b1, PROG_ERASE_ALLOW)
    for (int i = 0; i < 3; i++)
    begin
      fork
        model.op(i, 12);
        begin
          tick(6);
          rc(BUSY_STATUS_OFS, 8'h01 << bpos[i]);
        end
      join
      poll_idle(8'h01 << bpos[i]);
      tick(4);
      rc(BUSY_STATUS_OFS, 8'h00);
    end
    fork
      model.chip_erase(1'b0, 1'b0, 20);
      begin
        tick(8);
        rc(BUSY_STATUS_OFS, 8'h10);
      end
    join
    tick(8);
    rc(CE_STATUS_OFS, 8'h60);
    rc(BUSY_STATUS_OFS, 8'h00);
    `CHK("prog allow", 1'b0, PROG_ERASE_ALLOW)
    `CHK("irq", 1'b0, IRQ)
    wc(CE_STATUS_OFS, 8'h20);
    rc(CE_STATUS_OFS, 8'h20);
    `CHK("prog allow", 1'b0, PROG_ERASE_ALLOW)
    model.reset_cmd();
    `CHK("prog allow", 1'b1, PROG_ERASE_ALLOW)
    model.chip_erase(1'b1, 1'b1, 20);
    tick(8);
    rc(CE_STATUS_OFS, 8'h30);
    rc(BUSY_STATUS_OFS, 8'h01);
    `CHK("irq", 1'b1, IRQ)
    wc(CE_STATUS_OFS, 8'h10);
    tick(2);
    `CHK("irq", 1'b0, IRQ)
    rc(CE_STATUS_OFS, 8'h10);
    wc(CE_STATUS_OFS, 8'h30);
    tick(2);
    `CHK("irq", 1'b1, IRQ)
    wc(CE_STATUS_OFS, 8'h20);
    tick(2);
    `CHK("irq", 1'b0, IRQ)
    rc(CE_STATUS_OFS, 8'h20);
    model.reset_cmd();
    rc(BUSY_STATUS_OFS, 8'h01);
    // a sector once written to zero stays off until reset
    wc(SECTOR_WE_OFS, 8'h0e);
    wc(SECTOR_WE_OFS, 8'h0f);
    rc(SECTOR_WE_OFS, 8'h0e);
    tick(2);
    `CHK("sector allow", 4'he, SECTOR_WRITE_ALLOW)
    ARST_N <= 1'b0;
    tick(4);
    ARST_N <= 1'b1;
    tick(4);
    rc(BUSY_STATUS_OFS, 8'h00);
    rc(CE_STATUS_OFS, 8'h00);
    rc(SECTOR_WE_OFS, 8'h00);
    `CHK("irq", 1'b0, IRQ)
    `CHK("swap", 1'b0, SECTOR_SWAP_EN)
    results();
  end
endmodule : flash_prog_erase_status_tb_top
